// ### hdl/hraw_decode.sv
`timescale 1ns/1ps
// window hit, alignment and offset translation
module hraw_decode
    import hraw_pkg::*;
(
    // request address and size
    input wire logic [22:0] addr,
    input wire logic [1:0] size,
    // decode results
    output logic hit,
    output logic aligned,
    output logic [OFS_W-1:0] ofs
);
    // alignment check per size
    function automatic logic is_aligned(input logic [2:0] lo, input logic [1:0] sz);
        logic r;
        r = 1'b0;
        case (sz)
            SZ_WORD: r = (lo[0] == 1'b0);
            SZ_DWORD: r = (lo[1:0] == 2'b00);
            SZ_QWORD: r = (lo == 3'b000);
            default: r = 1'b0;
        endcase
        return r;
    endfunction : is_aligned

    // window compare and one-to-one offset
    always_comb begin
        hit = (addr >= WIN_BASE) && (addr <= WIN_LAST); // R1
        aligned = is_aligned(addr[2:0], size); // R3
        ofs = OFS_W'(addr - WIN_BASE); // R9
    end
endmodule : hraw_decode

// ### hdl/hraw_top.sv
`timescale 1ns/1ps
// Behaviour
// R1 - alias 140000h..17FFFFh onto host-bridge registers
// R2 - host bridge attributes apply unchanged
// R3 - only aligned word, dword, qword accesses
// R4 - forward only cpu-originated accesses
// R5 - streamer register store drops data
// R6 - streamer register load returns zero
// R7 - reachable through function 0 and 1
// R8 - function memory disable or power blocks
// R9 - forwarded offset equals address minus base
module hraw_top
    import hraw_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // upstream request
    input wire logic REQ_VALID,
    input wire logic REQ_SRC,
    input wire logic REQ_FUNC,
    input wire logic REQ_WRITE,
    input wire logic [22:0] REQ_ADDR,
    input wire logic [1:0] REQ_SIZE,
    input wire logic [63:0] REQ_WDATA,
    input wire logic [7:0] REQ_BE,
    // function enables and power
    input wire logic F0_MEM_EN,
    input wire logic F1_MEM_EN,
    input wire logic PWR_BLOCK,
    // upstream answer
    output logic REQ_READY,
    output logic RSP_VALID,
    output logic RSP_HIT,
    output logic RSP_ERR,
    output logic [63:0] RSP_RDATA,
    // host bridge register file
    output logic HB_VALID,
    output logic HB_WRITE,
    output logic [OFS_W-1:0] HB_OFS,
    output logic [63:0] HB_WDATA,
    output logic [7:0] HB_BE,
    input wire logic HB_DONE,
    input wire logic HB_ERR,
    input wire logic [63:0] HB_RDATA
);
    logic hit;
    logic aligned;
    logic [OFS_W-1:0] ofs;

    // window decode
    hraw_decode hraw_decode_inst (
        .addr(REQ_ADDR),
        .size(REQ_SIZE),
        .hit(hit),
        .aligned(aligned),
        .ofs(ofs)
    );

    hraw_state_t state, next_state;
    logic ready, next_ready;
    logic rsp_valid, next_rsp_valid;
    logic rsp_hit, next_rsp_hit;
    logic rsp_err, next_rsp_err;
    logic [63:0] rdata, next_rdata;
    logic hb_valid, next_hb_valid;
    logic hb_write, next_hb_write;
    logic [OFS_W-1:0] hb_ofs, next_hb_ofs;
    logic [63:0] hb_wdata, next_hb_wdata;
    logic [7:0] hb_be, next_hb_be;
    logic func_en;
    logic take;

    // per-function enable
    always_comb begin
        func_en = (REQ_FUNC ? F1_MEM_EN : F0_MEM_EN) && !PWR_BLOCK; // R7 R8
        take = REQ_VALID && ready && hit;
    end

    // request sequencing
    always_comb begin
        next_state = state;
        next_ready = ready;
        next_rsp_valid = 1'b0;
        next_rsp_hit = rsp_hit;
        next_rsp_err = rsp_err;
        next_rdata = rdata;
        next_hb_valid = 1'b0;
        next_hb_write = hb_write;
        next_hb_ofs = hb_ofs;
        next_hb_wdata = hb_wdata;
        next_hb_be = hb_be;
        case (state)
            ST_IDLE: begin
                next_ready = 1'b1;
                if (REQ_VALID && ready) begin
                    next_ready = 1'b0;
                    next_rsp_hit = hit;
                    if (!hit || !func_en) begin
                        // miss or blocked function: not claimed
                        next_rsp_valid = 1'b1;
                        next_rsp_err = 1'b0;
                        next_rsp_hit = 1'b0;
                        next_rdata = RD_ZERO;
                        next_state = ST_RESP;
                    end else if (!aligned) begin
                        next_rsp_valid = 1'b1; // R3
                        next_rsp_err = 1'b1;
                        next_rdata = RD_ZERO;
                        next_state = ST_RESP;
                    end else if (REQ_SRC == SRC_CS) begin
                        // streamer: writes dropped, reads zero
                        next_rsp_valid = 1'b1; // R4 R5
                        next_rsp_err = 1'b0;
                        next_rdata = RD_ZERO; // R6
                        next_state = ST_RESP;
                    end else begin
                        next_hb_valid = 1'b1; // R1 R4
                        next_hb_write = REQ_WRITE;
                        next_hb_ofs = ofs; // R9
                        next_hb_wdata = REQ_WDATA;
                        next_hb_be = REQ_BE;
                        next_state = ST_FWD;
                    end
                end
            end
            ST_FWD: begin
                // host bridge applies its own attributes
                if (HB_DONE) begin
                    next_rsp_valid = 1'b1;
                    next_rsp_err = HB_ERR; // R2
                    next_rdata = hb_write ? RD_ZERO : HB_RDATA;
                    next_state = ST_RESP;
                end
            end
            ST_RESP: begin
                next_ready = 1'b1;
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            state <= ST_IDLE;
            ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_hit <= 1'b0;
            rsp_err <= 1'b0;
            rdata <= RD_ZERO;
            hb_valid <= 1'b0;
            hb_write <= 1'b0;
            hb_ofs <= '0;
            hb_wdata <= 64'h0;
            hb_be <= 8'h0;
        end else begin
            state <= next_state;
            ready <= next_ready;
            rsp_valid <= next_rsp_valid;
            rsp_hit <= next_rsp_hit;
            rsp_err <= next_rsp_err;
            rdata <= next_rdata;
            hb_valid <= next_hb_valid;
            hb_write <= next_hb_write;
            hb_ofs <= next_hb_ofs;
            hb_wdata <= next_hb_wdata;
            hb_be <= next_hb_be;
        end
    end

    // outputs straight from flops
    assign REQ_READY = ready;
    assign RSP_VALID = rsp_valid;
    assign RSP_HIT = rsp_hit;
    assign RSP_ERR = rsp_err;
    assign RSP_RDATA = rdata;
    assign HB_VALID = hb_valid;
    assign HB_WRITE = hb_write;
    assign HB_OFS = hb_ofs;
    assign HB_WDATA = hb_wdata;
    assign HB_BE = hb_be;

    // helper: captured request attributes
    logic cap_cs;
    logic cap_ok;
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            cap_cs <= 1'b0;
            cap_ok <= 1'b0;
        end else if (REQ_VALID && ready) begin
            cap_cs <= (REQ_SRC == SRC_CS);
            cap_ok <= hit && func_en && aligned;
        end
    end

    // streamer never reaches host bridge
    cs_no_fwd_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R4
        (take && REQ_SRC == SRC_CS) |=> !hb_valid)
        else $error("streamer access forwarded");
    // streamer read returns zero in the next cycle
    cs_read_zero_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R6
        (take && func_en && aligned && REQ_SRC == SRC_CS && !REQ_WRITE) |=> (rsp_valid && rdata == 64'h0))
        else $error("streamer read not zero");
    // streamer write never issues a write
    cs_write_drop_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R5
        (take && REQ_SRC == SRC_CS && REQ_WRITE) |-> ##1 !hb_valid ##1 !hb_valid)
        else $error("streamer write forwarded");
    // cpu aligned hit forwards with translated offset
    cpu_fwd_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R9
        (take && func_en && aligned && REQ_SRC == SRC_CPU) |=>
        (hb_valid && hb_ofs == OFS_W'($past(REQ_ADDR) - WIN_BASE)))
        else $error("cpu access not forwarded at offset");
    // disabled function blocks forwarding
    func_off_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R8
        (REQ_VALID && ready && !func_en) |=> (!hb_valid && rsp_valid && !rsp_hit))
        else $error("disabled function forwarded");
    // misaligned gives error without forwarding
    misalign_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R3
        (take && func_en && !aligned) |=> (rsp_err && rsp_valid && !hb_valid))
        else $error("misaligned access accepted");
    // outside window is not claimed
    window_miss_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R1
        (REQ_VALID && ready && !hit) |=> (!rsp_hit && !hb_valid))
        else $error("out of window claimed");
    // host bridge status passes through
    hb_err_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R2
        (state == ST_FWD && HB_DONE) |=> (rsp_valid && rsp_err == $past(HB_ERR)))
        else $error("host bridge status lost");
    // forwarding only for vetted cpu requests
    fwd_cause_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R7
        $rose(hb_valid) |-> (cap_ok && !cap_cs))
        else $error("forward without cause");

    cov_cpu_rd: cover property (@(posedge SYS_CLK) take && REQ_SRC == SRC_CPU && !REQ_WRITE && func_en);
    cov_cpu_wr: cover property (@(posedge SYS_CLK) take && REQ_SRC == SRC_CPU && REQ_WRITE && func_en);
    cov_cs_rd: cover property (@(posedge SYS_CLK) take && REQ_SRC == SRC_CS && !REQ_WRITE);
    cov_f1_off: cover property (@(posedge SYS_CLK) REQ_VALID && ready && REQ_FUNC && !F1_MEM_EN);
endmodule : hraw_top

// ### pkg/hraw_pkg.sv
package hraw_pkg;
    // alias window bounds in graphics mmio byte space
    localparam logic [22:0] WIN_BASE = 23'h140000;
    localparam logic [22:0] WIN_LAST = 23'h17ffff;
    localparam int OFS_W = 18; // offset width inside the window
    // access sizes
    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_WORD = 2'b01,
        SZ_DWORD = 2'b10,
        SZ_QWORD = 2'b11
    } hraw_size_t;
    // requester sources
    typedef enum logic [0:0] {
        SRC_CPU = 1'b0,
        SRC_CS = 1'b1
    } hraw_src_t;
    // forwarding states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FWD = 2'b01,
        ST_RESP = 2'b10
    } hraw_state_t;
    localparam logic [63:0] RD_ZERO = 64'h0;
endpackage : hraw_pkg

// ### tb/hraw_hb_model.sv
`timescale 1ns/1ps
// host bridge register file stand-in
module hraw_hb_model
    import hraw_pkg::*;
#(
    parameter logic [OFS_W-1:0] RO_OFS = 18'h00100
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // forwarded request
    input wire logic hb_valid,
    input wire logic hb_write,
    input wire logic [OFS_W-1:0] hb_ofs,
    input wire logic [63:0] hb_wdata,
    input wire logic [7:0] hb_be,
    input wire logic slow,
    // answer
    output logic hb_done,
    output logic hb_err,
    output logic [63:0] hb_rdata
);
    logic [63:0] mem [0:(1 << OFS_W)-1];
    int i;
    // answer each forward after one or four cycles
    initial begin
        hb_done = 1'b0;
        hb_err = 1'b0;
        hb_rdata = 64'h0;
        // every place starts out cleared
        for (i = 0; i < (1 << OFS_W); i++) begin
            mem[i] = 64'h0;
        end
        forever begin
            @(posedge clk);
            if (rstn === 1'b1 && hb_valid === 1'b1) begin
                repeat (slow ? 4 : 1) @(posedge clk);
                // read-only place refuses writes and flags it
                hb_err <= hb_write && hb_ofs == RO_OFS;
                if (hb_write && hb_ofs != RO_OFS) begin
                    for (i = 0; i < 8; i++) begin
                        if (hb_be[i]) mem[hb_ofs][i*8 +: 8] = hb_wdata[i*8 +: 8];
                    end
                end
                hb_rdata <= hb_write ? 64'h0 : mem[hb_ofs];
                hb_done <= 1'b1;
                @(posedge clk);
                hb_done <= 1'b0;
                hb_err <= 1'b0;
                // released data no longer holds its value
                hb_rdata <= ~hb_rdata;
            end
        end
    end
endmodule : hraw_hb_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the alias window
module tb_top
    import hraw_pkg::*;
;
    localparam logic [OFS_W-1:0] RO = 18'h00100;
    logic sys_clk = 0, rstn = 0, v = 0, src = 0, func = 0, wr = 0;
    logic f0 = 1, f1 = 1, pwr = 0, slow = 0, ready, rv, rhit, rerr, hbv, hbw, done, herr, ghit, gerr;
    logic [22:0] addr = '0;
    logic [1:0] size = '0;
    logic [7:0] be = '0, hbbe;
    logic [OFS_W-1:0] hbofs;
    logic [63:0] wdata = '0, rdata, hbwd, hrd, got, pat = 64'hfedcba9876543210;
    int errors = 0, samples_checked = 0, fwd_total = 0, fwd_base = 0, k;
    int fwd;
    logic [22:0] a;
    hraw_top hraw_top_inst (.SYS_CLK(sys_clk), .RSTN(rstn), .REQ_VALID(v), .REQ_SRC(src),
        .REQ_FUNC(func), .REQ_WRITE(wr), .REQ_ADDR(addr), .REQ_SIZE(size), .REQ_WDATA(wdata),
        .REQ_BE(be), .F0_MEM_EN(f0), .F1_MEM_EN(f1), .PWR_BLOCK(pwr), .REQ_READY(ready),
        .RSP_VALID(rv), .RSP_HIT(rhit), .RSP_ERR(rerr), .RSP_RDATA(rdata), .HB_VALID(hbv),
        .HB_WRITE(hbw), .HB_OFS(hbofs), .HB_WDATA(hbwd), .HB_BE(hbbe), .HB_DONE(done),
        .HB_ERR(herr), .HB_RDATA(hrd));
    hraw_hb_model #(.RO_OFS(RO)) hraw_hb_model_inst (.clk(sys_clk), .rstn(rstn), .hb_valid(hbv),
        .hb_write(hbw), .hb_ofs(hbofs), .hb_wdata(hbwd), .hb_be(hbbe), .slow(slow),
        .hb_done(done), .hb_err(herr), .hb_rdata(hrd));
    // clock
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    // count forwards to the host bridge, relative to the current request
    always @(posedge sys_clk) begin
        if (hbv === 1'b1) fwd_total <= fwd_total + 1;
    end
    assign fwd = fwd_total - fwd_base;
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one request held until taken, then wait for its answer
    task automatic req(input logic s, input logic fn, input logic w, input logic [22:0] ad,
        input logic [1:0] sz, input logic [63:0] d);
        int n;
        n = 0;
        fwd_base = fwd_total;
        @(posedge sys_clk);
        {v, src, func, wr, addr, size, wdata} <= {1'b1, s, fn, w, ad, sz, d};
        be <= sz == SZ_QWORD ? 8'hff : (sz == SZ_DWORD ? 8'h0f : 8'h03);
        @(negedge sys_clk);
        while (ready !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        v <= 1'b0;
        @(negedge sys_clk);
        while (rv !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 100) check(64'h0, 64'h1);
        got = rdata;
        ghit = rhit;
        gerr = rerr;
    endtask : req
    // sizes across the window, both functions, last qword with a slow bridge
    task automatic t_window();
        for (k = 1; k < 4; k++) begin
            a = k == 3 ? WIN_LAST - 23'h7 : WIN_BASE + 23'(k * 16);
            slow = k == 3;
            req(SRC_CPU, k[0], 1'b1, a, 2'(k), pat);
            check(64'(hbofs), 64'(a - WIN_BASE));
            check(64'(fwd), 64'h1);
            req(SRC_CPU, ~k[0], 1'b0, a, 2'(k), 64'h0);
            check(got, k == 3 ? pat : pat & (k == 2 ? 64'hffffffff : 64'hffff));
            check(64'({ghit, gerr}), 64'h2);
        end
        $display("test window done");
    endtask : t_window
    // just outside either end of the window, and unaligned sizes
    task automatic t_edges();
        req(SRC_CPU, 1'b0, 1'b0, WIN_BASE - 23'h2, SZ_WORD, 64'h0);
        check(64'({ghit, 1'b0}) + 64'(fwd), 64'h0);
        req(SRC_CPU, 1'b0, 1'b1, WIN_LAST + 23'h1, SZ_DWORD, pat);
        check(64'({ghit, 1'b0}) + 64'(fwd), 64'h0);
        req(SRC_CPU, 1'b0, 1'b0, WIN_BASE, SZ_BYTE, 64'h0);
        check(64'({gerr, 1'b0}) + 64'(fwd), 64'h2);
        req(SRC_CPU, 1'b1, 1'b1, WIN_BASE + 23'h2, SZ_DWORD, pat);
        check(64'({gerr, 1'b0}) + 64'(fwd), 64'h2);
        $display("test edges done");
    endtask : t_edges
    // streamer accesses never reach the bridge
    task automatic t_stream();
        req(SRC_CS, 1'b0, 1'b1, WIN_BASE + 23'h10, SZ_WORD, 64'h0);
        check(64'(fwd), 64'h0);
        req(SRC_CS, 1'b0, 1'b0, WIN_BASE + 23'h10, SZ_WORD, 64'h0);
        check(got, RD_ZERO);
        check(64'({ghit, gerr}) + 64'(fwd), 64'h2);
        req(SRC_CPU, 1'b0, 1'b0, WIN_BASE + 23'h10, SZ_WORD, 64'h0);
        check(got, 64'h3210);
        $display("test streamer done");
    endtask : t_stream
    // memory disable per function and power block
    task automatic t_disable();
        @(posedge sys_clk);
        f0 <= 1'b0;
        req(SRC_CPU, 1'b0, 1'b0, WIN_BASE, SZ_QWORD, 64'h0);
        check(64'({ghit, 1'b0}) + 64'(fwd), 64'h0);
        req(SRC_CPU, 1'b1, 1'b0, WIN_BASE, SZ_QWORD, 64'h0);
        check(64'(ghit), 64'h1);
        @(posedge sys_clk);
        {f0, pwr} <= 2'b11;
        req(SRC_CPU, 1'b1, 1'b0, WIN_BASE, SZ_QWORD, 64'h0);
        check(64'({ghit, 1'b0}) + 64'(fwd), 64'h0);
        // function 1 off while function 0 still reaches the bridge
        @(posedge sys_clk);
        {f1, pwr} <= 2'b00;
        req(SRC_CPU, 1'b1, 1'b0, WIN_BASE, SZ_QWORD, 64'h0);
        check(64'({ghit, 1'b0}) + 64'(fwd), 64'h0);
        req(SRC_CPU, 1'b0, 1'b0, WIN_BASE, SZ_QWORD, 64'h0);
        check(64'({ghit, gerr}) + 64'(fwd), 64'h3);
        @(posedge sys_clk);
        f1 <= 1'b1;
        $display("test disable done");
    endtask : t_disable
    // bridge attributes show through the window
    task automatic t_attr();
        req(SRC_CPU, 1'b0, 1'b1, WIN_BASE + 23'(RO), SZ_QWORD, pat);
        check(64'({ghit, gerr}), 64'h3);
        req(SRC_CPU, 1'b0, 1'b0, WIN_BASE + 23'(RO), SZ_QWORD, 64'h0);
        check(got, 64'h0);
        $display("test attributes done");
    endtask : t_attr
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    // watchdog
    initial begin
        #(25 * 5000);
        errors++;
        end_of_test();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        t_window();
        t_edges();
        t_stream();
        t_disable();
        t_attr();
        end_of_test();
    end
endmodule : tb_top
